// ===== inc/lmt_pkg.sv
// Constants, types and helpers of the light measurement timing block.
// Assumes a 125 MHz system clock and byte-wide registers on a 32-bit bus.
package lmt_pkg;

  // Clock and modulator tick timing.
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned MOD_TICK_PS     = 1388889;
  localparam int unsigned MOD_TICK_CYCLES = MOD_TICK_PS / CLK_PERIOD_PS;
  localparam logic [7:0]  TICK_CNT_MAX    = 8'(MOD_TICK_CYCLES - 1);

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL      = 8'h80;
  localparam logic [7:0] IDX_MODE1     = 8'h82;
  localparam logic [7:0] IDX_SAMP_LO   = 8'h83;
  localparam logic [7:0] IDX_SAMP_HI   = 8'h84;
  localparam logic [7:0] IDX_STEPS_LO  = 8'h85;
  localparam logic [7:0] IDX_STEPS_HI  = 8'h86;
  localparam logic [7:0] IDX_FLK_LO    = 8'h87;
  localparam logic [7:0] IDX_FLK_HI    = 8'h88;
  localparam logic [7:0] IDX_WAIT      = 8'h89;
  localparam logic [7:0] IDX_DIV       = 8'ha0;
  localparam logic [7:0] IDX_TRIG      = 8'ha1;
  localparam logic [7:0] IDX_STATUS    = 8'ha2;

  // Field positions, field widths and the divider counter width.
  localparam int unsigned CTRL_PON_BIT    = 0;
  localparam int unsigned CTRL_LIGHT_BIT  = 1;
  localparam int unsigned CTRL_FLK_BIT    = 6;
  localparam int unsigned MODE1_MARK_BIT  = 7;
  localparam int unsigned FLK_FOREVER_BIT = 7;
  localparam int unsigned HI_W            = 3;
  localparam int unsigned DIV_W           = 3;
  localparam int unsigned DIV_CNT_W       = 7;

  // Reset values.
  localparam logic [7:0]       RST_SAMP_LO = 8'hb3;
  localparam logic [7:0]       RST_BYTE    = 8'h00;
  localparam logic [HI_W-1:0]  RST_HI      = 3'h0;
  localparam logic [DIV_W-1:0] RST_DIV     = 3'h0;
  localparam logic [7:0]       RST_TRIG    = 8'h01;

  // Sequencer states.
  typedef enum logic [1:0] {
    LMT_IDLE,
    LMT_RUN,
    LMT_WAIT
  } lmt_state_t;

  // Joins an upper three-bit field and a low byte into an 11-bit value.
  function automatic logic [10:0] lmt_join11(input logic [HI_W-1:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

endpackage

// ===== hw/lmt_tick_gen.sv
// Modulator tick generator with a power-of-two divider.
// Assumes run_i and div_i are synchronous register outputs.
`timescale 1ns/1ps
module lmt_tick_gen (
  input  wire logic                      sys_clk_i, // System clock.
  input  wire logic                      reset_i,   // Synchronous reset.
  input  wire logic                      run_i,     // Oscillator running.
  input  wire logic [lmt_pkg::DIV_W-1:0] div_i,     // Divider selection.
  output logic                           tick_o     // One-cycle tick.
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  logic [7:0]                    pre_cnt_r, pre_cnt_nxt;
  logic [lmt_pkg::DIV_CNT_W-1:0] div_cnt_r, div_cnt_nxt;
  logic [lmt_pkg::DIV_CNT_W-1:0] div_lim;
  logic                          tick_r, tick_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Base period and divider; all counting stops while the oscillator is off.
  // base tick period
  always_comb begin
    div_lim     = 7'((7'h01 << div_i) - 7'h01);
    pre_cnt_nxt = pre_cnt_r + 8'h01;
    div_cnt_nxt = div_cnt_r;
    tick_nxt    = 1'b0;
    if (!run_i) begin
      pre_cnt_nxt = 8'h00;
      div_cnt_nxt = '0;
    end else if (pre_cnt_r == lmt_pkg::TICK_CNT_MAX) begin
      pre_cnt_nxt = 8'h00;
      if (div_cnt_r >= div_lim) begin
        div_cnt_nxt = '0;
        tick_nxt    = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 7'h01;
      end
    end
  end

  // Registers of the tick generator.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pre_cnt_r <= 8'h00;
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

  AST_TICK_BASE: assert property (tick_r |-> $past(pre_cnt_r) == lmt_pkg::TICK_CNT_MAX)
    else $error("Tick without a full base period.");
  AST_TICK_DIV: assert property (tick_r |-> $past(div_cnt_r) >= $past(div_lim))
    else $error("Tick before the divider count ended.");
  AST_TICK_OFF: assert property (!run_i |=> !tick_r)
    else $error("Tick while the oscillator is off.");

endmodule

// ===== hw/lmt_timing.sv
// Light measurement timing block: registers, sequencer and Wishbone slave.
// Assumes a classic Wishbone master on sys_clk_i and a synchronous reset.
`timescale 1ns/1ps
module lmt_timing (
  input  wire logic        sys_clk_i,        // System clock, 125 MHz.
  input  wire logic        reset_i,          // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,         // Wishbone cycle.
  input  wire logic        wb_stb_i,         // Wishbone strobe.
  input  wire logic        wb_we_i,          // Wishbone write enable.
  input  wire logic [9:0]  wb_adr_i,         // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,         // Wishbone write data.
  output logic      [31:0] wb_dat_o,         // Wishbone read data.
  output logic             wb_ack_o,         // Wishbone acknowledge.
  output logic             osc_run_o,        // Oscillator running.
  output logic             meas_active_o,    // Measurement in progress.
  output logic             flicker_sample_o, // Flicker sample taken.
  output logic             light_step_o,     // Light integration step done.
  output logic             light_done_o,     // Light integration complete.
  output logic             end_marker_o      // End marker into the FIFO.
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // Register file.
  logic                          ack_r, ack_nxt;
  logic [31:0]                   dat_r, dat_nxt;
  logic                          pon_r, pon_nxt;
  logic                          light_en_r, light_en_nxt;
  logic                          flk_en_r, flk_en_nxt;
  logic                          mark_en_r, mark_en_nxt;
  logic [7:0]                    samp_lo_r, samp_lo_nxt;
  logic [lmt_pkg::HI_W-1:0]      samp_hi_r, samp_hi_nxt;
  logic [7:0]                    steps_lo_r, steps_lo_nxt;
  logic [lmt_pkg::HI_W-1:0]      steps_hi_r, steps_hi_nxt;
  logic [7:0]                    flk_lo_r, flk_lo_nxt;
  logic [lmt_pkg::HI_W-1:0]      flk_hi_r, flk_hi_nxt;
  logic                          forever_r, forever_nxt;
  logic [7:0]                    wait_r, wait_nxt;
  logic [lmt_pkg::DIV_W-1:0]     div_r, div_nxt;
  logic [7:0]                    trig_r, trig_nxt;
  logic                          req, wr;
  logic [7:0]                    idx, wbyte, rbyte;

  // Sequencer.
  lmt_pkg::lmt_state_t           state_r, state_nxt;
  logic [10:0]                   samp_cnt_r, samp_cnt_nxt;
  logic [10:0]                   step_cnt_r, step_cnt_nxt;
  logic [10:0]                   flk_cnt_r, flk_cnt_nxt;
  logic [15:0]                   wait_cnt_r, wait_cnt_nxt;
  logic [10:0]                   lat_per_r, lat_per_nxt;
  logic [10:0]                   lat_steps_r, lat_steps_nxt;
  logic [10:0]                   lat_flk_r, lat_flk_nxt;
  logic                          lat_forever_r, lat_forever_nxt;
  logic                          lat_light_r, lat_light_nxt;
  logic                          lat_flk_en_r, lat_flk_en_nxt;
  logic                          flk_fin_r, flk_fin_nxt;
  logic                          light_fin_r, light_fin_nxt;
  logic                          fs_r, fs_nxt, ls_r, ls_nxt, ld_r, ld_nxt, em_r, em_nxt;
  logic                          tick, run_en, start, meas_end;
  logic                          act_r, act_nxt;
  logic [15:0]                   wait_total;

  //////////////////////////////////////////////////////////////////////////////
  // Modulator tick source, stopped while power is off.
  lmt_tick_gen u_tick (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (pon_r),
    .div_i     (div_r),
    .tick_o    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode, register writes and read mux; ack follows one cycle later.
  always_comb begin
    req          = wb_cyc_i & wb_stb_i & ~ack_r;
    idx          = wb_adr_i[9:2];
    wr           = req & wb_we_i & wb_sel_i[0];
    wbyte        = wb_dat_i[7:0];
    ack_nxt      = req;
    pon_nxt      = pon_r;
    light_en_nxt = light_en_r;
    flk_en_nxt   = flk_en_r;
    mark_en_nxt  = mark_en_r;
    samp_lo_nxt  = samp_lo_r;
    samp_hi_nxt  = samp_hi_r;
    steps_lo_nxt = steps_lo_r;
    steps_hi_nxt = steps_hi_r;
    flk_lo_nxt   = flk_lo_r;
    flk_hi_nxt   = flk_hi_r;
    forever_nxt  = forever_r;
    wait_nxt     = wait_r;
    div_nxt      = div_r;
    trig_nxt     = trig_r;
    rbyte        = 8'h00;
    if (wr) begin
      unique case (idx)
        lmt_pkg::IDX_CTRL: begin
          pon_nxt      = wbyte[lmt_pkg::CTRL_PON_BIT];
          light_en_nxt = wbyte[lmt_pkg::CTRL_LIGHT_BIT] & wbyte[lmt_pkg::CTRL_PON_BIT];
          flk_en_nxt   = wbyte[lmt_pkg::CTRL_FLK_BIT] & wbyte[lmt_pkg::CTRL_PON_BIT];
        end
        lmt_pkg::IDX_MODE1:    mark_en_nxt  = wbyte[lmt_pkg::MODE1_MARK_BIT];
        lmt_pkg::IDX_SAMP_LO:  samp_lo_nxt  = wbyte;
        lmt_pkg::IDX_SAMP_HI:  samp_hi_nxt  = wbyte[lmt_pkg::HI_W-1:0];
        lmt_pkg::IDX_STEPS_LO: steps_lo_nxt = wbyte;
        lmt_pkg::IDX_STEPS_HI: steps_hi_nxt = wbyte[lmt_pkg::HI_W-1:0];
        lmt_pkg::IDX_FLK_LO:   flk_lo_nxt   = wbyte;
        lmt_pkg::IDX_FLK_HI: begin
          flk_hi_nxt  = wbyte[lmt_pkg::HI_W-1:0];
          forever_nxt = wbyte[lmt_pkg::FLK_FOREVER_BIT];
        end
        lmt_pkg::IDX_WAIT:     wait_nxt     = wbyte;
        lmt_pkg::IDX_DIV:      div_nxt      = wbyte[lmt_pkg::DIV_W-1:0];
        lmt_pkg::IDX_TRIG:     trig_nxt     = wbyte;
        default:               ;
      endcase
    end
    unique case (idx)
      lmt_pkg::IDX_CTRL:     rbyte = {1'b0, flk_en_r, 4'h0, light_en_r, pon_r};
      lmt_pkg::IDX_MODE1:    rbyte = {mark_en_r, 7'h00};
      lmt_pkg::IDX_SAMP_LO:  rbyte = samp_lo_r;
      lmt_pkg::IDX_SAMP_HI:  rbyte = {5'h00, samp_hi_r};
      lmt_pkg::IDX_STEPS_LO: rbyte = steps_lo_r;
      lmt_pkg::IDX_STEPS_HI: rbyte = {5'h00, steps_hi_r};
      lmt_pkg::IDX_FLK_LO:   rbyte = flk_lo_r;
      lmt_pkg::IDX_FLK_HI:   rbyte = {forever_r, 4'h0, flk_hi_r};
      lmt_pkg::IDX_WAIT:     rbyte = wait_r;
      lmt_pkg::IDX_DIV:      rbyte = {5'h00, div_r};
      lmt_pkg::IDX_TRIG:     rbyte = trig_r;
      lmt_pkg::IDX_STATUS:   rbyte = {5'h00, state_r == lmt_pkg::LMT_WAIT,
                                      state_r == lmt_pkg::LMT_RUN, pon_r};
      default:               rbyte = 8'h00;
    endcase
    dat_nxt = req ? {24'h000000, rbyte} : 32'h00000000;
  end

  // Registers of the bus group.
  // sample period reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ack_r      <= 1'b0;
      dat_r      <= 32'h00000000;
      pon_r      <= 1'b0;
      light_en_r <= 1'b0;
      flk_en_r   <= 1'b0;
      mark_en_r  <= 1'b0;
      samp_lo_r  <= lmt_pkg::RST_SAMP_LO;
      samp_hi_r  <= lmt_pkg::RST_HI;
      steps_lo_r <= lmt_pkg::RST_BYTE;
      steps_hi_r <= lmt_pkg::RST_HI;
      flk_lo_r   <= lmt_pkg::RST_BYTE;
      flk_hi_r   <= lmt_pkg::RST_HI;
      forever_r  <= 1'b0;
      wait_r     <= lmt_pkg::RST_BYTE;
      div_r      <= lmt_pkg::RST_DIV;
      trig_r     <= lmt_pkg::RST_TRIG;
    end else begin
      ack_r      <= ack_nxt;
      dat_r      <= dat_nxt;
      pon_r      <= pon_nxt;
      light_en_r <= light_en_nxt;
      flk_en_r   <= flk_en_nxt;
      mark_en_r  <= mark_en_nxt;
      samp_lo_r  <= samp_lo_nxt;
      samp_hi_r  <= samp_hi_nxt;
      steps_lo_r <= steps_lo_nxt;
      steps_hi_r <= steps_hi_nxt;
      flk_lo_r   <= flk_lo_nxt;
      flk_hi_r   <= flk_hi_nxt;
      forever_r  <= forever_nxt;
      wait_r     <= wait_nxt;
      div_r      <= div_nxt;
      trig_r     <= trig_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: sample periods, flicker and light counts, and the wait gap.
  always_comb begin
    run_en          = pon_r & (light_en_r | flk_en_r);
    wait_total      = wait_r * trig_r;
    state_nxt       = state_r;
    samp_cnt_nxt    = samp_cnt_r;
    step_cnt_nxt    = step_cnt_r;
    flk_cnt_nxt     = flk_cnt_r;
    wait_cnt_nxt    = wait_cnt_r;
    lat_per_nxt     = lat_per_r;
    lat_steps_nxt   = lat_steps_r;
    lat_flk_nxt     = lat_flk_r;
    lat_forever_nxt = lat_forever_r;
    lat_light_nxt   = lat_light_r;
    lat_flk_en_nxt  = lat_flk_en_r;
    flk_fin_nxt     = flk_fin_r;
    light_fin_nxt   = light_fin_r;
    fs_nxt          = 1'b0;
    ls_nxt          = 1'b0;
    ld_nxt          = 1'b0;
    em_nxt          = 1'b0;
    start           = 1'b0;
    meas_end        = 1'b0;
    unique case (state_r)
      lmt_pkg::LMT_IDLE: start = run_en;
      lmt_pkg::LMT_RUN: begin
        if (tick && samp_cnt_r == lat_per_r) begin
          samp_cnt_nxt = 11'h000;
          if (lat_flk_en_r && !flk_fin_r) begin
            fs_nxt = 1'b1;
            if (flk_cnt_r == lat_flk_r) begin
              flk_cnt_nxt = 11'h000;
              flk_fin_nxt = !lat_forever_r;
              em_nxt      = mark_en_r & !lat_forever_r;
            end else begin
              flk_cnt_nxt = flk_cnt_r + 11'h001;
            end
          end
          if (lat_light_r && !light_fin_r) begin
            ls_nxt = 1'b1;
            if (step_cnt_r == lat_steps_r) begin
              light_fin_nxt = 1'b1;
              ld_nxt        = 1'b1;
            end else begin
              step_cnt_nxt = step_cnt_r + 11'h001;
            end
          end
          meas_end = (flk_fin_nxt | !lat_flk_en_r) & (light_fin_nxt | !lat_light_r);
        end else if (tick) begin
          samp_cnt_nxt = samp_cnt_r + 11'h001;
        end
        if (meas_end && wait_total == 16'h0000) begin
          start = 1'b1;
        end else if (meas_end) begin
          state_nxt    = lmt_pkg::LMT_WAIT;
          wait_cnt_nxt = 16'h0000;
        end
      end
      lmt_pkg::LMT_WAIT: begin
        if (tick && wait_cnt_r == wait_total - 16'h0001) begin
          start = 1'b1;
        end else if (tick) begin
          wait_cnt_nxt = wait_cnt_r + 16'h0001;
        end
      end
      default: state_nxt = lmt_pkg::LMT_IDLE;
    endcase
    if (start) begin
      state_nxt       = lmt_pkg::LMT_RUN;
      lat_per_nxt     = lmt_pkg::lmt_join11(samp_hi_r, samp_lo_r);
      lat_steps_nxt   = lmt_pkg::lmt_join11(steps_hi_r, steps_lo_r);
      lat_flk_nxt     = lmt_pkg::lmt_join11(flk_hi_r, flk_lo_r);
      lat_forever_nxt = forever_r;
      lat_light_nxt   = light_en_r;
      lat_flk_en_nxt  = flk_en_r;
      samp_cnt_nxt    = 11'h000;
      step_cnt_nxt    = 11'h000;
      flk_cnt_nxt     = 11'h000;
      flk_fin_nxt     = 1'b0;
      light_fin_nxt   = 1'b0;
    end
    if (!run_en) begin
      state_nxt = lmt_pkg::LMT_IDLE;
    end
    // Activity flag follows the next state so the output comes from a flip-flop.
    act_nxt = (state_nxt == lmt_pkg::LMT_RUN);
  end

  // Registers of the sequencer group.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_r       <= lmt_pkg::LMT_IDLE;
      samp_cnt_r    <= 11'h000;
      step_cnt_r    <= 11'h000;
      flk_cnt_r     <= 11'h000;
      wait_cnt_r    <= 16'h0000;
      lat_per_r     <= 11'h000;
      lat_steps_r   <= 11'h000;
      lat_flk_r     <= 11'h000;
      lat_forever_r <= 1'b0;
      lat_light_r   <= 1'b0;
      lat_flk_en_r  <= 1'b0;
      flk_fin_r     <= 1'b0;
      light_fin_r   <= 1'b0;
      fs_r          <= 1'b0;
      ls_r          <= 1'b0;
      ld_r          <= 1'b0;
      em_r          <= 1'b0;
      act_r         <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      samp_cnt_r    <= samp_cnt_nxt;
      step_cnt_r    <= step_cnt_nxt;
      flk_cnt_r     <= flk_cnt_nxt;
      wait_cnt_r    <= wait_cnt_nxt;
      lat_per_r     <= lat_per_nxt;
      lat_steps_r   <= lat_steps_nxt;
      lat_flk_r     <= lat_flk_nxt;
      lat_forever_r <= lat_forever_nxt;
      lat_light_r   <= lat_light_nxt;
      lat_flk_en_r  <= lat_flk_en_nxt;
      flk_fin_r     <= flk_fin_nxt;
      light_fin_r   <= light_fin_nxt;
      fs_r          <= fs_nxt;
      ls_r          <= ls_nxt;
      ld_r          <= ld_nxt;
      em_r          <= em_nxt;
      act_r         <= act_nxt;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = dat_r;
  assign osc_run_o        = pon_r;
  assign meas_active_o    = act_r;
  assign flicker_sample_o = fs_r;
  assign light_step_o     = ls_r;
  assign light_done_o     = ld_r;
  assign end_marker_o     = em_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held for two cycles.");
  AST_SAMP_RANGE: assert property (meas_active_o |-> samp_cnt_r <= lat_per_r)
    else $error("Sample counter passed the period.");
  AST_SAMP_RESET: assert property ($fell(reset_i) |-> samp_lo_r == 8'hb3 && samp_hi_r == 3'h0)
    else $error("Sample period reset value wrong.");
  AST_LIGHT_DONE: assert property (light_done_o |-> light_step_o &&
                                   $past(step_cnt_r) == $past(lat_steps_r))
    else $error("Light done before the last step.");
  AST_FLK_COUNT: assert property (meas_active_o |-> flk_cnt_r <= lat_flk_r)
    else $error("Flicker count passed its limit.");
  AST_FOREVER_NOMARK: assert property (end_marker_o |->
                                       !$past(lat_forever_r) && $past(mark_en_r))
    else $error("End marker in repeat-forever mode.");
  AST_WAIT_RANGE: assert property (state_r == lmt_pkg::LMT_WAIT |-> wait_cnt_r < wait_total)
    else $error("Wait counter passed the wait length.");
  AST_ZERO_WAIT: assert property (wait_total == 16'h0000 |-> state_r != lmt_pkg::LMT_WAIT)
    else $error("Wait entered with zero wait.");
  AST_POWER_OFF: assert property (!pon_r |->
                                  (!light_en_r && !flk_en_r) ##1 !meas_active_o)
    else $error("Activity without power.");
  AST_MARKER: assert property (fs_r && flk_fin_r && $rose(flk_fin_r) && $past(mark_en_r)
                               |-> end_marker_o)
    else $error("End marker missing.");
  AST_LATCH_HOLD: assert property (meas_active_o && $past(meas_active_o) && !$past(start)
                                   |-> $stable(lat_per_r) && $stable(lat_flk_r))
    else $error("Latched timing changed mid-measurement.");

  COV_MARKER: cover property (end_marker_o);
  COV_LIGHT: cover property (light_done_o);
  COV_WAIT: cover property (state_r == lmt_pkg::LMT_WAIT ##1 meas_active_o);

endmodule

// ===== bench/lmt_timing_tb_top.sv
// Self-checking testbench of the light measurement timing block.
// Assumes the design answers every Wishbone access with a one-cycle ack.
`timescale 1ns/1ps
module lmt_timing_tb_top;
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, osc_run, meas_act, flk_smp, lgt_step, lgt_done, end_mark;
  int          err_total = 0;
  int          checked = 0;
  int          n, cnt_s, cnt_m;
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 8 ns period and the block under test.
  always #4 sys_clk = ~sys_clk;
  lmt_timing i_lmt_timing (.sys_clk_i(sys_clk), .reset_i(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .osc_run_o(osc_run), .meas_active_o(meas_act),
    .flicker_sample_o(flk_smp), .light_step_o(lgt_step), .light_done_o(lgt_done),
    .end_marker_o(end_mark));
  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One classic Wishbone access, held until ack is sampled high.
  task automatic wb_acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] q);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= 4'hf;
    wdat <= {24'h0, d};
    k = 0;
    do begin @(posedge sys_clk); k++; end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 50) begin err_total++; final_report(); end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb_acc(1'b1, idx, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    wb_acc(1'b0, idx, 8'h00, q);
    check(q, {24'h0, exp}, "register read");
  endtask
  // Selects one of the timing pulses by number.
  function automatic logic pulse(input int which);
    case (which)
      0: return lgt_step;
      1: return lgt_done;
      2: return flk_smp;
      default: return end_mark;
    endcase
  endfunction
  // Waits for a pulse within a bounded number of cycles; n holds the cycles waited.
  task automatic wait_pulse(input int which, input int lim);
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pulse(which) !== 1'b1 && n < lim);
    if (n >= lim) begin err_total++; final_report(); end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(lmt_pkg::IDX_SAMP_LO, 8'hb3);
    for (int i = 8'h84; i <= 8'h89; i++) rd_chk(8'(i), 8'h00);
    rd_chk(8'h10, 8'h00);
    wr(8'h10, 8'h5a);
    rd_chk(8'h10, 8'h00);
    wr(lmt_pkg::IDX_SAMP_HI, 8'h05);
    rd_chk(lmt_pkg::IDX_SAMP_HI, 8'h05);
    // Light channel: period 0, two steps, no divider.
    wr(lmt_pkg::IDX_SAMP_HI, 8'h00);
    wr(lmt_pkg::IDX_SAMP_LO, 8'h00);
    wr(lmt_pkg::IDX_STEPS_LO, 8'h01);
    wr(lmt_pkg::IDX_CTRL, 8'h03);
    check(osc_run, 1'b1, "power bit");
    wait_pulse(1, 2000);
    wait_pulse(0, 400);
    check(lgt_done, 1'b0, "first step done");
    wait_pulse(0, 400);
    check(n, 32'(lmt_pkg::MOD_TICK_CYCLES), "step length");
    check(lgt_done, 1'b1, "last step done");
    wr(lmt_pkg::IDX_CTRL, 8'h00);
    @(posedge sys_clk);
    check(osc_run, 1'b0, "power off");
    check(meas_act, 1'b0, "idle");
    rd_chk(lmt_pkg::IDX_CTRL, 8'h00);
    // Flicker channel: period 1, divide by two, three samples, end markers on.
    wr(lmt_pkg::IDX_SAMP_LO, 8'h01);
    wr(lmt_pkg::IDX_DIV, 8'h01);
    wr(lmt_pkg::IDX_FLK_LO, 8'h02);
    wr(lmt_pkg::IDX_MODE1, 8'h80);
    wr(lmt_pkg::IDX_CTRL, 8'h41);
    wait_pulse(3, 20000);
    cnt_s = 0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (flk_smp === 1'b1) cnt_s++;
    end while (end_mark !== 1'b1 && n < 20000);
    if (n >= 20000) begin err_total++; final_report(); end
    check(cnt_s, 3, "samples per step");
    check(flk_smp, 1'b1, "marker with last sample");
    wait_pulse(2, 3000);
    check(n, 32'(4 * lmt_pkg::MOD_TICK_CYCLES), "zero wait restart");
    wait_pulse(2, 3000);
    check(n, 32'(4 * lmt_pkg::MOD_TICK_CYCLES), "divided sample");
    // Wait of two units of three ticks, then two ticks to the first sample.
    wr(lmt_pkg::IDX_WAIT, 8'h02);
    wr(lmt_pkg::IDX_TRIG, 8'h03);
    wait_pulse(3, 5000);
    wait_pulse(2, 4000);
    check(n, 32'((2 * 3 + 2) * 2 * lmt_pkg::MOD_TICK_CYCLES), "wait gap");
    wr(lmt_pkg::IDX_WAIT, 8'h00);
    // Forever mode: samples keep coming, no markers.
    wr(lmt_pkg::IDX_FLK_HI, 8'h80);
    repeat (4000) @(posedge sys_clk);
    cnt_s = 0;
    cnt_m = 0;
    repeat (8000) begin
      @(posedge sys_clk);
      if (flk_smp === 1'b1) cnt_s++;
      if (end_mark === 1'b1) cnt_m++;
    end
    check(cnt_m, 0, "markers in forever mode");
    check(cnt_s >= 11, 1'b1, "samples in forever mode");
    final_report();
  end
  // Cuts a hang short.
  initial begin
    #640000;
    err_total++;
    final_report();
  end
endmodule
